// >>> dv/dss_alu_asserts.sv
// Port checker for dss_alu
`timescale 1ns/10ps
module dss_alu_asserts (
	input wire logic                sys_clk,
	input wire logic                nrst,
	input wire dss_pkg::dss_instr_t instr,
	input wire logic [7:0]          memRdData,
	input wire dss_pkg::dss_memwr_t memWr,
	input wire logic [7:0]          acc,
	input wire dss_pkg::dss_flags_t flags,
	input wire logic [11:0]         pc,
	input wire logic                skipActive,
	input wire logic                busy
);
	import dss_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire t  = instr.valid && !busy;
	wire sb = t && instr.op == DSS_OP_SBCM;
	wire tz = t && instr.op[1] && memRdData == 8'h01;
	a_sub_result: assert property (sb |=> memWr.we && memWr.data == $past(acc)
		- $past(memRdData) - {7'h0, !$past(flags.c)}) else $error("sub data");
	a_carry_sign: assert property (sb |=> flags.c == ($past(acc) >=
		$past(memRdData) + {8'h0, !$past(flags.c)})) else $error("carry");
	a_decm_write: assert property (t && instr.op == DSS_OP_DECM |=> memWr.we &&
		memWr.data == $past(memRdData) - 8'h01) else $error("dec write");
	a_dummy_cycle: assert property (t && instr.op[1] |=> busy ##1 !busy)
		else $error("dummy");
	a_busy_refuse: assert property (busy |=> !memWr.we)
		else $error("write in dummy cycle");
	a_acc_load: assert property (t && instr.op == DSS_OP_DECA |=> !memWr.we &&
		acc == $past(memRdData) - 8'h01) else $error("acc load");
	a_no_skip: assert property (t && instr.op[1] && !tz |=> !skipActive ##1
		pc == $past(pc, 2) + 12'h1) else $error("no skip");
	a_skip_one: assert property (tz |=> skipActive ##1 pc == $past(pc, 2) + 12'h2)
		else $error("skip");
endmodule

// >>> dv/dss_alu_tb_top.sv
// Self-checking testbench for dss_alu
`timescale 1ns/10ps
module dss_alu_tb_top;
	import dss_pkg::*;
	logic        sys_clk, nrst, skipActive, busy;
	logic [7:0]  memRdData, acc;
	logic [11:0] pc;
	dss_instr_t  instr;
	dss_memwr_t  memWr;
	dss_flags_t  flags;
	int          error_cnt = 0, n_compared = 0;
	dss_alu dss_alu_inst (.sys_clk, .nrst, .instr, .memRdData, .memWr, .acc, .flags,
		.pc, .skipActive, .busy);
	initial begin
		sys_clk = 0;
		forever #2 sys_clk = ~sys_clk;
	end
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task issue(input dss_op_t o, input logic [7:0] m);
		instr = '{1'b1, o, 8'h20};
		memRdData = m;
		@(posedge sys_clk);
		#1;
	endtask
	task dec_run(input dss_op_t o, input logic [7:0] m);
		logic [11:0] p;
		logic [7:0]  d;
		p = pc;
		d = m - 8'h01;
		issue(o, m);
		chk(o == DSS_OP_DECM ? memWr.data : acc, d);
		chk(memWr.we, o == DSS_OP_DECM);
		chk({skipActive, busy}, {m == 8'h01, 1'b1});
		// A request in the dummy cycle must be ignored
		instr.op = DSS_OP_SBCM;
		@(posedge sys_clk);
		#1;
		chk(memWr.we, 1'b0);
		chk(pc, p + 12'h1 + (m == 8'h01));
		$display("decrement test done");
	endtask
	task sub_run(input logic [7:0] m, input logic [8:0] exp, input logic [5:0] ef);
		issue(DSS_OP_SBCM, m);
		chk({flags.c, memWr.data}, exp);
		chk(flags, ef);
		chk({memWr.we, memWr.addr}, 9'h120);
		$display("subtract test done");
	endtask
	task none_run;
		logic [11:0] p;
		p = pc;
		instr = '{1'b1, DSS_OP_NONE, 8'h20};
		@(posedge sys_clk);
		#1;
		chk(pc, p + 12'h1);
		chk({memWr.we, busy, skipActive}, 3'h0);
		$display("no-op test done");
	endtask
	task reset_run;
		nrst = 0;
		@(posedge sys_clk);
		#1;
		chk(acc, 8'h00);
		chk(pc, 12'h000);
		chk(flags, 6'h00);
		chk({memWr.we, busy, skipActive}, 3'h0);
		nrst = 1;
		$display("reset test done");
	endtask
	initial begin
		nrst = 0;
		instr = '0;
		memRdData = 8'h00;
		repeat (5) @(posedge sys_clk);
		#1;
		nrst = 1;
		dec_run(DSS_OP_DECM, 8'h01);
		dec_run(DSS_OP_DECM, 8'h00);
		dec_run(DSS_OP_DECA, 8'h01);
		dec_run(DSS_OP_DECA, 8'h06);
		none_run;
		sub_run(8'h03, 9'h101, 6'h0c);
		sub_run(8'h07, 9'h0fe, 6'h02);
		sub_run(8'h04, 9'h100, 6'h1c);
		sub_run(8'h05, 9'h100, 6'h1d);
		reset_run;
		dec_run(DSS_OP_DECM, 8'h01);
		end_sim;
	end
	initial begin
		#2000;
		error_cnt++;
		end_sim;
	end
endmodule
bind dss_alu dss_alu_asserts dss_alu_asserts_inst (.sys_clk, .nrst, .instr, .memRdData,
	.memWr, .acc, .flags, .pc, .skipActive, .busy);

// >>> verilog/dss_alu.sv
// Decrement-skip and subtract-with-borrow datapath with program counter
`timescale 1ns/10ps

// Summary of operation
// - Subtract-with-borrow: memory gets ACC minus operand minus inverted carry; flags update.
// - Carry clears on negative result, sets on zero or positive.
// - Memory decrement stores operand minus one; skip next instruction when zero.
// - Decrement-skip takes two cycles; a dummy replaces the skipped instruction.
// - Accumulator decrement loads ACC with operand minus one; memory untouched.
// - Non-zero decrement result still takes the dummy cycle, then continues with the next instruction.
module dss_alu (
	input  wire logic                      sys_clk,
	input  wire logic                      nrst,
	input  wire dss_pkg::dss_instr_t       instr,
	input  wire logic [dss_pkg::DATA_W-1:0] memRdData,
	output dss_pkg::dss_memwr_t            memWr,
	output logic [dss_pkg::DATA_W-1:0]     acc,
	output dss_pkg::dss_flags_t            flags,
	output logic [dss_pkg::PC_W-1:0]       pc,
	output logic                           skipActive,
	output logic                           busy
);
	import dss_pkg::*;

	typedef struct packed {
		dss_state_t        st;
		logic [DATA_W-1:0] acc;
		dss_flags_t        flags;
		dss_memwr_t        wr;
		logic [PC_W-1:0]   pc;
		logic              skip;
		logic              busy;
	} dss_regs_t;

	dss_regs_t state_r;
	dss_regs_t state_nxt;

	logic [DATA_W-1:0] subDiff;
	dss_flags_t        subFlags;
	logic [DATA_W-1:0] decVal;
	logic              decZero;

	////////////////////////////////////////////////////////////////////////////////
	dss_sub_unit uSub (
		.minuend    (state_r.acc),
		.subtrahend (memRdData),
		.carryIn    (state_r.flags.c),
		.prevZ      (state_r.flags.z),
		.diff       (subDiff),
		.flags      (subFlags)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		decVal  = memRdData - DEC_ONE;
		decZero = (decVal == 8'h00);
		state_nxt        = state_r;
		state_nxt.wr.we  = 1'b0;
		state_nxt.skip   = 1'b0;
		state_nxt.busy   = 1'b0;
		unique case (state_r.st)
			DSS_ST_RUN: begin
				if (instr.valid) begin
					state_nxt.pc = state_r.pc + 12'h001;
					unique case (instr.op)
						DSS_OP_SBCM: begin
							state_nxt.wr.we   = 1'b1;
							state_nxt.wr.addr = instr.addr;
							state_nxt.wr.data = subDiff;
							state_nxt.flags   = subFlags;
						end
						DSS_OP_DECM: begin
							state_nxt.wr.we   = 1'b1;
							state_nxt.wr.addr = instr.addr;
							state_nxt.wr.data = decVal;
							state_nxt.st   = DSS_ST_FILL;
							state_nxt.busy = 1'b1;
							state_nxt.skip = decZero;
						end
						DSS_OP_DECA: begin
							state_nxt.acc  = decVal;
							state_nxt.st   = DSS_ST_FILL;
							state_nxt.busy = 1'b1;
							state_nxt.skip = decZero;
						end
						DSS_OP_NONE: begin
							state_nxt.pc = state_r.pc + 12'h001;
						end
					endcase
				end
			end
			DSS_ST_FILL: begin
				state_nxt.st = DSS_ST_RUN;
				if (state_r.skip) begin
					state_nxt.pc = state_r.pc + 12'h001;
				end
			end
			default: begin
				state_nxt.st = DSS_ST_RUN;
			end
		endcase
		if (!nrst) begin
			state_nxt.st    = DSS_ST_RUN;
			state_nxt.acc   = ACC_RST;
			state_nxt.flags = '0;
			state_nxt.wr    = '0;
			state_nxt.pc    = PC_RST;
			state_nxt.skip  = 1'b0;
			state_nxt.busy  = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		state_r <= state_nxt;
	end

	assign memWr      = state_r.wr;
	assign acc        = state_r.acc;
	assign flags      = state_r.flags;
	assign pc         = state_r.pc;
	assign skipActive = state_r.skip;
	assign busy       = state_r.busy;
endmodule

// >>> verilog/dss_pkg.sv
// Package: types and constants for the decrement/skip/subtract datapath
package dss_pkg;

	localparam int DATA_W    = 8;
	localparam int ADDR_W    = 8;
	localparam int PC_W      = 12;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [11:0] PC_RST = 12'h000;
	localparam logic [7:0] DEC_ONE = 8'h01;

	typedef enum logic [1:0] {
		DSS_OP_NONE  = 2'h0,
		DSS_OP_SBCM  = 2'h1,
		DSS_OP_DECM  = 2'h2,
		DSS_OP_DECA  = 2'h3
	} dss_op_t;

	// One issued instruction from the fetch path
	typedef struct packed {
		logic             valid;
		dss_op_t          op;
		logic [ADDR_W-1:0] addr;
	} dss_instr_t;

	// Status flags touched by the subtract
	typedef struct packed {
		logic ov;
		logic z;
		logic ac;
		logic c;
		logic sc;
		logic cz;
	} dss_flags_t;

	// Data memory write port
	typedef struct packed {
		logic             we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} dss_memwr_t;

	typedef enum logic [1:0] {
		DSS_ST_RUN  = 2'b00,
		DSS_ST_FILL = 2'b01
	} dss_state_t;

endpackage

// >>> verilog/dss_sub_unit.sv
// Byte subtractor with borrow and flag generation
`timescale 1ns/10ps
module dss_sub_unit (
	input  wire logic [7:0]         minuend,
	input  wire logic [7:0]         subtrahend,
	input  wire logic               carryIn,
	input  wire logic               prevZ,
	output logic [7:0]              diff,
	output dss_pkg::dss_flags_t     flags
);
	import dss_pkg::*;

	logic [8:0] full;
	logic [4:0] low;

	always_comb begin
		full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, ~carryIn};
		low  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, ~carryIn};
		diff = full[7:0];
		flags.c  = ~full[8];
		flags.ac = ~low[4];
		flags.z  = (full[7:0] == 8'h00);
		flags.ov = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full[7]);
		flags.sc = full[7] ^ flags.ov;
		flags.cz = flags.z & prevZ;
	end
endmodule
